// File: bench/gpbcd_pins.sv
// pin-side partner: resolves each port pin from the block and the far side
module gpbcd_pins (
  // block driver side, ports d c b packed high to low
  input  wire logic [23:0] out,
  input  wire logic [23:0] oe,
  input  wire logic [7:0]  pu,
  // far-side drive and its enables
  input  wire logic [23:0] ext,
  input  wire logic [23:0] ee,
  output logic      [23:0] pin
);
  // a released pin follows the far side
  // only a port b pull-up lifts an undriven pin
  // a pin nobody drives or pulls up shows the inverse of the block's out bit, never a stale value
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      pin[i] = oe[i] ? out[i] : ee[i] ? ext[i] : (i < 8 && pu[i[2:0]]) ? 1'b1 : ~out[i];
    end
  end
endmodule // gpbcd_pins

// File: bench/test_gpio_ports_b_c_d.sv
// self-checking bench for the port b/c/d block
module test_gpio_ports_b_c_d;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 0, aresetn = 0, por_bor_n = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, mode;
  logic [31:0] wdata = 0, rdata, rv;
  logic [1:0]  bresp, rresp;
  logic [7:0]  b_out, b_oe, pu, c_out, c_oe, d_out, d_oe, sp_in, pc_in, opts;
  logic [7:0]  sel = 0, p_out = 0, p_oe = 0, s_out = 0, v[6];
  logic        s_oe = 0, s_if = 0, s_of = 0, s_ov = 0;
  logic [23:0] ext = 0, ee = 24'hffffff, pin;
  int          n_errors = 0, checks_done = 0, seed = 32'hef13;
  int          ra[7] = '{'h204, 'h604, 'h218, 'h618, 'h21c, 'h220, 'h224};
  int          rx[7] = '{'hff, 'hff, 'hff, 'hff, 'hff, 'hff, 'h07};

  always #4 aclk = ~aclk;

  gpbcd_top dut (.aclk(aclk), .aresetn(aresetn), .por_bor_n(por_bor_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_b_in(pin[7:0]), .port_b_out(b_out), .port_b_oe(b_oe), .port_b_pullup_en(pu),
    .port_c_in(pin[15:8]), .port_c_out(c_out), .port_c_oe(c_oe), .periph_c_sel(sel),
    .periph_c_out(p_out), .periph_c_oe(p_oe), .periph_c_in(pc_in),
    .port_d_in(pin[23:16]), .port_d_out(d_out), .port_d_oe(d_oe),
    .slave_port_out(s_out), .slave_port_oe(s_oe), .slave_input_full(s_if),
    .slave_output_full(s_of), .slave_overflow_set(s_ov), .slave_port_in(sp_in),
    .parallel_slave_mode(mode), .timer_pullup_options(opts));

  gpbcd_pins pins (.out({d_out, c_out, b_out}), .oe({d_oe, c_oe, b_oe}), .pu(pu),
    .ext(ext), .ee(ee), .pin(pin));

  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // a wait that ran out counts as a mismatch and ends the run
  task automatic stall(int i);
    if (i >= 40) begin
      n_errors++;
      $display("mismatch bus answer expected within 40 cycles seen none");
      conclude();
    end
  endtask

  // write: address and data offered together, each dropped once taken
  task automatic wr(logic [11:0] a, logic [7:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    stall(i);
    bready <= 1'b0;
    rv = {30'h0, bresp};
  endtask

  task automatic rd(logic [11:0] a);
    int i;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    stall(i);
    rready <= 1'b0;
    rv = rdata;
  endtask

  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    por_bor_n <= 1'b1;
    foreach (ra[k]) begin
      rd(ra[k][11:0]);
      chk("reset value", rv, rx[k]);
    end
    chk("pullup off", pu, 8'h00);
    rd(12'h3fc);
    chk("unmapped read resp", {30'h0, rresp}, gpbcd_pkg::RESP_SLVERR);
    wr(12'h3fc, 8'h5a);
    chk("unmapped write resp", rv, gpbcd_pkg::RESP_SLVERR);
    $display("test reset values done");
    // direction_c is always written whole, never read-modify-write
    for (int n = 0; n < 4; n++) begin
      foreach (v[j]) v[j] = $random(seed);
      ext <= $random(seed);
      wr(12'h018, v[0]);
      wr(12'h01c, v[1]);
      wr(12'h020, v[2]);
      wr(12'h618, v[3]);
      wr(12'h21c, v[4]);
      wr(12'h220, v[5]);
      wr(12'h604, {1'b0, v[0][6:0]});
      repeat (3) @(posedge aclk);
      chk("c_oe", c_oe, 8'(~v[4]));
      chk("b_oe", b_oe, 8'(~v[3]));
      chk("c_out", c_out, v[1]);
      chk("d_oe", d_oe, 8'(~v[5]));
      chk("b_out", b_out, v[0]);
      chk("pullup", pu, v[3]);
      chk("options", opts, {1'b0, v[0][6:0]});
      chk("periph_in", pc_in, pin[15:8]);
      rd(12'h418);
      chk("b pins", rv, (v[3] & ext[7:0]) | (~v[3] & v[0]));
      rd(12'h01c);
      chk("c pins", rv, (v[4] & ext[15:8]) | (~v[4] & v[1]));
      rd(12'h220);
      chk("d dir", rv, v[5]);
      rd(12'h218);
      chk("b dir alias", rv, v[3]);
    end
    $display("test latches and directions done");
    // one peripheral select at a time, other enables must be ignored
    for (int i = 0; i < 8; i++) begin
      @(posedge aclk);
      sel <= 8'h01 << i;
      p_oe <= $random(seed);
      p_out <= $random(seed);
      repeat (3) @(posedge aclk);
      chk("override oe", c_oe, 8'((~v[4] & ~sel) | (p_oe & sel)));
      chk("override out", c_out, (v[1] & ~sel) | (p_out & sel));
    end
    sel <= 8'h00;
    s_out <= $random(seed);
    s_oe <= 1'b1;
    s_of <= 1'b1;
    wr(12'h224, 8'h97);
    repeat (3) @(posedge aclk);
    chk("slave mode", {31'h0, mode}, 32'h1);
    chk("slave data", d_out, s_out);
    chk("slave oe", d_oe, 8'hff);
    chk("sel released", c_oe, 8'(~v[4]));
    chk("slave in", sp_in, s_out);
    rd(12'h224);
    chk("status", rv, 32'h57);
    s_ov <= 1'b1;
    @(posedge aclk);
    s_ov <= 1'b0;
    s_of <= 1'b0;
    rd(12'h224);
    chk("overflow", rv, 32'h37);
    $display("test override and slave port done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h224);
    chk("status reset", rv, 32'h07);
    wr(12'h21c, 8'h00);
    repeat (3) @(posedge aclk);
    chk("latch kept", c_out, v[1]);
    rd(12'h3c0);
    chk("latch flag set", rv, 32'h1);
    por_bor_n <= 1'b0;
    repeat (2) @(posedge aclk);
    por_bor_n <= 1'b1;
    wr(12'h21c, 8'h00);
    repeat (3) @(posedge aclk);
    chk("latch cleared", c_out, 8'h00);
    rd(12'h3c0);
    chk("latch flag clear", rv, 32'h0);
    $display("test resets done");
    conclude();
  end
endmodule // test_gpio_ports_b_c_d

// File: rtl/gpbcd_pin_mux.sv
// per-pin direction, peripheral override and output select for one port
module gpbcd_pin_mux #(
  parameter int WIDTH = 8
) (
  // port state
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] direction,
  // peripheral side
  input  wire logic [WIDTH-1:0] periph_sel,
  input  wire logic [WIDTH-1:0] periph_out,
  input  wire logic [WIDTH-1:0] periph_oe,
  // driver side
  output logic      [WIDTH-1:0] drive_value,
  output logic      [WIDTH-1:0] drive_en
);

  // one mux per pin; periph_oe counts only while selected
  for (genvar i = 0; i < WIDTH; i++) begin : g_pin
    always_comb begin
      if (periph_sel[i]) begin
        drive_value[i] = periph_out[i];
        drive_en[i]    = periph_oe[i];
      end else begin
        drive_value[i] = latch[i];
        drive_en[i]    = ~direction[i];
      end
    end
  end

endmodule // gpbcd_pin_mux

// File: rtl/gpbcd_pkg.sv
// register map, field layout and reset values for the port b/c/d block
package gpbcd_pkg;

  // ------------------------------------------------------------
  // register indices (printed offsets; byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [8:0] IDX_PIN_DATA_B       = 9'h006;
  localparam logic [8:0] IDX_PIN_DATA_B_ALT   = 9'h106;
  localparam logic [8:0] IDX_PIN_DATA_C       = 9'h007;
  localparam logic [8:0] IDX_PIN_DATA_D       = 9'h008;
  localparam logic [8:0] IDX_OPTIONS          = 9'h081;
  localparam logic [8:0] IDX_OPTIONS_ALT      = 9'h181;
  localparam logic [8:0] IDX_DIRECTION_B      = 9'h086;
  localparam logic [8:0] IDX_DIRECTION_B_ALT  = 9'h186;
  localparam logic [8:0] IDX_DIRECTION_C      = 9'h087;
  localparam logic [8:0] IDX_DIRECTION_D      = 9'h088;
  localparam logic [8:0] IDX_DIRECTION_E      = 9'h089;
  localparam logic [8:0] IDX_RESET_CAUSE      = 9'h0f0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_DIRECTION        = 8'hff;
  localparam logic [7:0] RST_OPTIONS          = 8'hff;
  localparam logic [7:0] RST_DIRECTION_E      = 8'h07;
  localparam logic [7:0] RST_LATCH            = 8'h00;

  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int OPT_PULLUP_DISABLE_N = 7;
  localparam int TRE_INPUT_FULL       = 7;
  localparam int TRE_OUTPUT_FULL      = 6;
  localparam int TRE_INPUT_OVERFLOW   = 5;
  localparam int TRE_SLAVE_MODE       = 4;
  localparam logic [7:0] TRE_WRITE_MASK = 8'h37;

  // ------------------------------------------------------------
  // axi response codes
  // ------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : gpbcd_pkg

// File: rtl/gpbcd_top.sv
// port b, c and d register file, pin drivers and axi4-lite slave
// Behaviour
// - port c has eight pins, each with its own direction bit
// - enabled peripheral forces port c pin direction, only while enabled
// - per-pin select picks port latch or peripheral output for port c
// - peripheral output enable honoured only while its select is active
// - c0 timer1 osc out/clock in, c1 osc in/capture_compare_pwm_2, c2 capture_compare_pwm_1
// - c3 serial clock, c4 spi in/i2c data, c5 serial data out
// - c6 usart transmit/clock, c7 usart receive/data
// - port d has eight pins, each with its own direction bit
// - slave mode bit 4 of port e register turns port d into slave port
// - in slave mode each port d pin carries slave data bit of same index
// - port c and d directions reset to all ones on every reset
// - port b data and direction reachable at two offsets; direction resets ones
// - output latches keep contents across resets other than power-on/brown-out
// - options register at 81h/181h, resets ones, holds pull-up and timer fields
// - port e register layout fixed, resets to 0000 -111 on every reset
// - direction bit set makes pin input; clear drives from latch
// - clearing pull-up disable enables port b pull-ups, never on outputs
//
// Design decision made here: the AXI4-Lite register port.
module gpbcd_top #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              por_bor_n,
  // axi4-lite write address
  input  wire logic [11:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // axi4-lite read data
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // port b pins
  input  wire logic [WIDTH-1:0]  port_b_in,
  output logic [WIDTH-1:0]       port_b_out,
  output logic [WIDTH-1:0]       port_b_oe,
  output logic [WIDTH-1:0]       port_b_pullup_en,
  // port c pins
  input  wire logic [WIDTH-1:0]  port_c_in,
  output logic [WIDTH-1:0]       port_c_out,
  output logic [WIDTH-1:0]       port_c_oe,
  // port c peripherals (bit i = pin i)
  input  wire logic [WIDTH-1:0]  periph_c_sel,
  input  wire logic [WIDTH-1:0]  periph_c_out,
  input  wire logic [WIDTH-1:0]  periph_c_oe,
  output logic [WIDTH-1:0]       periph_c_in,
  // port d pins
  input  wire logic [WIDTH-1:0]  port_d_in,
  output logic [WIDTH-1:0]       port_d_out,
  output logic [WIDTH-1:0]       port_d_oe,
  // parallel slave port side
  input  wire logic [WIDTH-1:0]  slave_port_out,
  input  wire logic              slave_port_oe,
  input  wire logic              slave_input_full,
  input  wire logic              slave_output_full,
  input  wire logic              slave_overflow_set,
  output logic [WIDTH-1:0]       slave_port_in,
  output logic                   parallel_slave_mode,
  // options fields to timer0 and interrupt logic
  output logic [7:0]             timer_pullup_options
);

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [WIDTH-1:0] latch_b, latch_c, latch_d;
  logic [WIDTH-1:0] direction_b, direction_c, direction_d;
  logic [7:0]       options;
  logic [7:0]       direction_e;
  logic             latch_valid;

  // ------------------------------------------------------------
  // axi write path
  // ------------------------------------------------------------
  logic             aw_held, w_held;
  logic [8:0]       aw_idx;
  logic [31:0]      w_data;
  logic [3:0]       w_strb;
  logic             wr_go;
  logic             wr_hit;

  // address and data taken in either order, one write at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx  <= 9'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx  <= s_axi_awaddr[10:2];
    end else if (wr_go) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held <= 1'b0;
    end
  end

  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  // ready registered so outputs come from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid && !wr_go;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid && !wr_go;
    end
  end

  // decode of write index, aliases included
  always_comb begin
    case (aw_idx)
      gpbcd_pkg::IDX_PIN_DATA_B, gpbcd_pkg::IDX_PIN_DATA_B_ALT,
      gpbcd_pkg::IDX_PIN_DATA_C, gpbcd_pkg::IDX_PIN_DATA_D,
      gpbcd_pkg::IDX_OPTIONS, gpbcd_pkg::IDX_OPTIONS_ALT,
      gpbcd_pkg::IDX_DIRECTION_B, gpbcd_pkg::IDX_DIRECTION_B_ALT,
      gpbcd_pkg::IDX_DIRECTION_C, gpbcd_pkg::IDX_DIRECTION_D,
      gpbcd_pkg::IDX_DIRECTION_E, gpbcd_pkg::IDX_RESET_CAUSE: wr_hit = 1'b1;
      default:                                                wr_hit = 1'b0;
    endcase
  end

  // write response, slverr on unmapped index
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpbcd_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? gpbcd_pkg::RESP_OKAY : gpbcd_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic       wr_byte0;
  logic [7:0] wv;
  assign wr_byte0 = wr_go && w_strb[0];
  assign wv       = w_data[7:0];

  // ------------------------------------------------------------
  // port registers
  // ------------------------------------------------------------
  // latches only cleared by power-on/brown-out
  // por_bor_n low in same cycle as aresetn is the power-on case
  // latch write ignores direction
  always_ff @(posedge aclk) begin
    if (!por_bor_n) begin
      latch_b     <= gpbcd_pkg::RST_LATCH;
      latch_c     <= gpbcd_pkg::RST_LATCH;
      latch_d     <= gpbcd_pkg::RST_LATCH;
      latch_valid <= 1'b0;
    end else if (wr_byte0) begin
      if (aw_idx == gpbcd_pkg::IDX_PIN_DATA_B || aw_idx == gpbcd_pkg::IDX_PIN_DATA_B_ALT)
        latch_b <= wv;
      if (aw_idx == gpbcd_pkg::IDX_PIN_DATA_C)
        latch_c <= wv;
      if (aw_idx == gpbcd_pkg::IDX_PIN_DATA_D)
        latch_d <= wv;
      // only a data latch write makes the latches defined
      if (aw_idx == gpbcd_pkg::IDX_PIN_DATA_B || aw_idx == gpbcd_pkg::IDX_PIN_DATA_B_ALT ||
          aw_idx == gpbcd_pkg::IDX_PIN_DATA_C || aw_idx == gpbcd_pkg::IDX_PIN_DATA_D)
        latch_valid <= 1'b1;
    end
  end

  // directions all ones on every reset
  always_ff @(posedge aclk) begin
    if (!aresetn || !por_bor_n) begin
      direction_b <= gpbcd_pkg::RST_DIRECTION;
      direction_c <= gpbcd_pkg::RST_DIRECTION;
      direction_d <= gpbcd_pkg::RST_DIRECTION;
    end else if (wr_byte0) begin
      if (aw_idx == gpbcd_pkg::IDX_DIRECTION_B || aw_idx == gpbcd_pkg::IDX_DIRECTION_B_ALT)
        direction_b <= wv;
      if (aw_idx == gpbcd_pkg::IDX_DIRECTION_C)
        direction_c <= wv;
      if (aw_idx == gpbcd_pkg::IDX_DIRECTION_D)
        direction_d <= wv;
    end
  end

  // options at both offsets, resets to ones
  always_ff @(posedge aclk) begin
    if (!aresetn || !por_bor_n) begin
      options <= gpbcd_pkg::RST_OPTIONS;
    end else if (wr_byte0 && (aw_idx == gpbcd_pkg::IDX_OPTIONS || aw_idx == gpbcd_pkg::IDX_OPTIONS_ALT)) begin
      options <= wv;
    end
  end

  // full flags follow slave, overflow sticky, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn || !por_bor_n) begin
      direction_e <= gpbcd_pkg::RST_DIRECTION_E;
    end else begin
      direction_e[gpbcd_pkg::TRE_INPUT_FULL]  <= slave_input_full;
      direction_e[gpbcd_pkg::TRE_OUTPUT_FULL] <= slave_output_full;
      direction_e[3]                          <= 1'b0;
      if (wr_byte0 && aw_idx == gpbcd_pkg::IDX_DIRECTION_E) begin
        direction_e[gpbcd_pkg::TRE_SLAVE_MODE] <= wv[gpbcd_pkg::TRE_SLAVE_MODE];
        direction_e[2:0]                       <= wv[2:0];
        direction_e[gpbcd_pkg::TRE_INPUT_OVERFLOW] <= wv[gpbcd_pkg::TRE_INPUT_OVERFLOW] || slave_overflow_set;
      end else if (slave_overflow_set) begin
        direction_e[gpbcd_pkg::TRE_INPUT_OVERFLOW] <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // pin logic
  // ------------------------------------------------------------
  logic [WIDTH-1:0] c_val, c_en, d_val, d_en;

  // pins 0..2 map timer1 and ccp by index
  // pins 3..5 map serial port by index
  // pins 6..7 map usart by index
  gpbcd_pin_mux #(.WIDTH(WIDTH)) u_mux_c (
    .latch       (latch_c),
    .direction   (direction_c),
    .periph_sel  (periph_c_sel),
    .periph_out  (periph_c_out),
    .periph_oe   (periph_c_oe),
    .drive_value (c_val),
    .drive_en    (c_en)
  );

  // slave bit i on pin i
  gpbcd_pin_mux #(.WIDTH(WIDTH)) u_mux_d (
    .latch       (latch_d),
    .direction   (direction_d),
    .periph_sel  ({WIDTH{direction_e[gpbcd_pkg::TRE_SLAVE_MODE]}}),
    .periph_out  (slave_port_out),
    .periph_oe   ({WIDTH{slave_port_oe}}),
    .drive_value (d_val),
    .drive_en    (d_en)
  );

  // registered pin outputs, one cycle after the state changes
  // direction set means high impedance
  // pull-ups only on inputs and when enabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_b_out       <= '0;
      port_b_oe        <= '0;
      port_b_pullup_en <= '0;
      port_c_out       <= '0;
      port_c_oe        <= '0;
      port_d_out       <= '0;
      port_d_oe        <= '0;
    end else begin
      port_b_out       <= latch_b;
      port_b_oe        <= ~direction_b;
      port_b_pullup_en <= direction_b & {WIDTH{~options[gpbcd_pkg::OPT_PULLUP_DISABLE_N]}};
      port_c_out       <= c_val;
      port_c_oe        <= c_en;
      port_d_out       <= d_val;
      port_d_oe        <= d_en;
    end
  end

  // pin levels toward peripherals and status outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      periph_c_in          <= '0;
      slave_port_in        <= '0;
      parallel_slave_mode  <= 1'b0;
      timer_pullup_options <= gpbcd_pkg::RST_OPTIONS;
    end else begin
      periph_c_in          <= port_c_in;
      slave_port_in        <= port_d_in;
      parallel_slave_mode  <= direction_e[gpbcd_pkg::TRE_SLAVE_MODE];
      timer_pullup_options <= options;
    end
  end

  // ------------------------------------------------------------
  // axi read path
  // ------------------------------------------------------------
  logic [7:0] rd_val;
  logic       rd_hit;

  always_comb begin
    rd_hit = 1'b1;
    case (s_axi_araddr[10:2])
      gpbcd_pkg::IDX_PIN_DATA_B, gpbcd_pkg::IDX_PIN_DATA_B_ALT: rd_val = port_b_in;
      gpbcd_pkg::IDX_PIN_DATA_C:                                rd_val = port_c_in;
      gpbcd_pkg::IDX_PIN_DATA_D:                                rd_val = port_d_in;
      gpbcd_pkg::IDX_OPTIONS, gpbcd_pkg::IDX_OPTIONS_ALT:       rd_val = options;
      gpbcd_pkg::IDX_DIRECTION_B, gpbcd_pkg::IDX_DIRECTION_B_ALT: rd_val = direction_b;
      gpbcd_pkg::IDX_DIRECTION_C:                               rd_val = direction_c;
      gpbcd_pkg::IDX_DIRECTION_D:                               rd_val = direction_d;
      gpbcd_pkg::IDX_DIRECTION_E:                               rd_val = direction_e;
      gpbcd_pkg::IDX_RESET_CAUSE:                               rd_val = {7'h00, latch_valid};
      default: begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // one read at a time, answer the cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= gpbcd_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, rd_val};
      s_axi_rresp   <= rd_hit ? gpbcd_pkg::RESP_OKAY : gpbcd_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  property p_dir_c_reset;
    @(posedge aclk) $rose(aresetn) |-> direction_c == 8'hff && direction_d == 8'hff;
  endproperty
  a_dir_c_reset: assert property (p_dir_c_reset) else $error("port c/d direction not ones after reset");

  property p_direction_e_slave_status_reset;
    @(posedge aclk) $rose(aresetn) |-> direction_e[7:4] == 4'h0 && direction_e[2:0] == 3'h7;
  endproperty
  a_direction_e_slave_status_reset: assert property (p_direction_e_slave_status_reset) else $error("port e register reset wrong");

  property p_c_override;
    @(posedge aclk) disable iff (!aresetn)
      periph_c_sel[0] |=> port_c_oe[0] == $past(periph_c_oe[0]) && port_c_out[0] == $past(periph_c_out[0]);
  endproperty
  a_c_override: assert property (p_c_override) else $error("peripheral override not applied");

  property p_c_port_dir;
    @(posedge aclk) disable iff (!aresetn)
      !periph_c_sel[7] |=> port_c_oe[7] == !$past(direction_c[7]) && port_c_out[7] == $past(latch_c[7]);
  endproperty
  a_c_port_dir: assert property (p_c_port_dir) else $error("port c pin not from latch");

  property p_d_slave;
    @(posedge aclk) disable iff (!aresetn)
      direction_e[4] |=> port_d_out == $past(slave_port_out) && port_d_oe == {8{$past(slave_port_oe)}};
  endproperty
  a_d_slave: assert property (p_d_slave) else $error("slave mode not on port d");

  property p_b_dir;
    @(posedge aclk) disable iff (!aresetn) 1'b1 |=> port_b_oe == ~$past(direction_b);
  endproperty
  a_b_dir: assert property (p_b_dir) else $error("port b enable not inverse of direction");

  property p_pullup;
    @(posedge aclk) disable iff (!aresetn)
      port_b_pullup_en == (~port_b_oe & {8{~timer_pullup_options[gpbcd_pkg::OPT_PULLUP_DISABLE_N]}});
  endproperty
  a_pullup: assert property (p_pullup) else $error("pull-up on an output pin");

  property p_ovf_sticky;
    @(posedge aclk) disable iff (!aresetn) slave_overflow_set |=> direction_e[5];
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow event lost");

  property p_latch_keep;
    @(posedge aclk) por_bor_n && !aresetn && !wr_byte0 |=> latch_c == $past(latch_c);
  endproperty
  a_latch_keep: assert property (p_latch_keep) else $error("latch lost on warm reset");

  property p_rd_answer;
    @(posedge aclk) disable iff (!aresetn) s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered in one cycle");

  c_slave: cover property (@(posedge aclk) disable iff (!aresetn) direction_e[4] && slave_port_oe);
  c_override: cover property (@(posedge aclk) disable iff (!aresetn) periph_c_sel[6] && periph_c_oe[6]);
  c_write: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bready);

endmodule // gpbcd_top
